//--- hw/gmh_pkg.sv
// shared constants for the instrument bus message handler
package gmh_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int IFC_MIN_NS = 100000;
  // least time rounds up
  localparam int IFC_CYCLES = (IFC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_WAIT_CYCLES = 16;

  // ----------------------------------------
  // bus command bytes (seven bits used)
  // ----------------------------------------
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_PPC = 8'h05;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_TCT = 8'h09;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_PPU = 8'h15;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [7:0] CMD_UNT = 8'h5f;
  localparam logic [7:0] CMD_MASK = 8'h7f;
  localparam logic [7:0] GROUP_MASK = 8'h60;

  // ----------------------------------------
  // status byte layout
  // ----------------------------------------
  localparam int SB_RQS_BIT = 6;
  localparam int SB_REASON_W = 6;

  // ----------------------------------------
  // controller operations
  // ----------------------------------------
  localparam int OP_W = 4;
  localparam logic [3:0] OP_SEND_DATA = 4'h0;
  localparam logic [3:0] OP_TRIGGER = 4'h1;
  localparam logic [3:0] OP_CLR_ADDR = 4'h2;
  localparam logic [3:0] OP_CLR_ALL = 4'h3;
  localparam logic [3:0] OP_REMOTE = 4'h4;
  localparam logic [3:0] OP_LOCAL = 4'h5;
  localparam logic [3:0] OP_LOCKOUT = 4'h6;
  localparam logic [3:0] OP_REN_OFF = 4'h7;
  localparam logic [3:0] OP_SPOLL = 4'h8;
  localparam logic [3:0] OP_PASS = 4'h9;
  localparam logic [3:0] OP_ABORT = 4'ha;

  // step kinds of a controller sequence
  localparam logic [1:0] STEP_CMD = 2'h0;
  localparam logic [1:0] STEP_DATA = 2'h1;
  localparam logic [1:0] STEP_WAIT = 2'h2;
  localparam int SEQ_DEPTH = 4;

  // address byte from a group base and a five-bit bus address
  function automatic logic [7:0] addr_byte(input logic [7:0] base, input logic [4:0] a);
    return base | {3'h0, a};
  endfunction

endpackage

//--- hw/gmh_bus_if.sv
// bus between the controller end and the instrument end
`timescale 1ns/1ps
interface gmh_bus_if;
  logic atn;
  logic ren;
  logic ifc;
  logic [7:0] ctl_dio;
  logic ctl_dav;
  logic [7:0] dev_dio;
  logic dev_dav;
  logic srq;

  modport ctl (
    output atn, ren, ifc, ctl_dio, ctl_dav,
    input dev_dio, dev_dav, srq
  );
  modport dev (
    input atn, ren, ifc, ctl_dio, ctl_dav,
    output dev_dio, dev_dav, srq
  );
endinterface

//--- hw/gmh_device.sv
// instrument end: addressing, trigger, clear, remote/local, service request
`timescale 1ns/1ps
module gmh_device #(
  parameter logic [4:0] MY_ADDR = 5'h0b
) (
  input wire logic i_clk, // system clock
  input wire logic i_reset_n, // async reset, active low
  gmh_bus_if.dev bus, // bus to controller
  input wire logic i_local_req, // front panel local key
  input wire logic i_need_service, // service condition level
  input wire logic [5:0] i_reason, // service reason code
  input wire logic [7:0] i_tx_data, // byte to talk
  input wire logic i_tx_valid, // talk byte offered
  output logic o_tx_ready, // talk byte taken this cycle
  output logic [7:0] o_rx_data, // received data byte
  output logic o_rx_valid, // received byte pulse
  output logic o_trigger, // trigger pulse
  output logic o_clear, // clear pulse
  output logic o_remote, // remote operation
  output logic o_lockout // local lockout active
);

  logic listen, talk, spoll, sb_sent, remote, lockout, srq_pend, need_q;
  logic [7:0] dio, rx_data;
  logic dav, rx_valid, trig, clr, tx_ready;
  logic next_listen, next_talk, next_spoll, next_sb_sent, next_remote, next_lockout;
  logic next_srq_pend, next_dav, next_rx_valid, next_trig, next_clr, next_tx_ready;
  logic [7:0] next_dio, next_rx_data;
  logic [7:0] cmd;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    cmd = bus.ctl_dio & gmh_pkg::CMD_MASK;
    next_listen = listen;
    next_talk = talk;
    next_spoll = spoll;
    next_sb_sent = sb_sent;
    next_remote = remote;
    next_lockout = lockout;
    next_srq_pend = srq_pend;
    next_dio = dio;
    next_dav = 1'b0;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    next_trig = 1'b0;
    next_clr = 1'b0;
    if (bus.ifc) begin
      next_listen = 1'b0;
      next_talk = 1'b0;
      next_spoll = 1'b0;
    end else if (bus.ctl_dav && bus.atn) begin
      if (cmd == gmh_pkg::addr_byte(gmh_pkg::LISTEN_BASE, MY_ADDR)) begin
        next_listen = 1'b1;
        if (bus.ren) begin
          next_remote = 1'b1;
        end
      end else if (cmd == gmh_pkg::CMD_UNL) begin
        next_listen = 1'b0;
      end else if (cmd == gmh_pkg::addr_byte(gmh_pkg::TALK_BASE, MY_ADDR)) begin
        next_talk = 1'b1;
        next_sb_sent = 1'b0;
      end else if ((cmd & gmh_pkg::GROUP_MASK) == gmh_pkg::TALK_BASE) begin
        // another talker or untalk
        next_talk = 1'b0;
      end else begin
        case (cmd)
          gmh_pkg::CMD_GET: next_trig = listen;
          gmh_pkg::CMD_SDC: next_clr = listen;
          gmh_pkg::CMD_DCL: next_clr = 1'b1;
          gmh_pkg::CMD_GTL: begin
            if (listen) begin
              next_remote = 1'b0;
            end
          end
          gmh_pkg::CMD_LLO: next_lockout = 1'b1;
          gmh_pkg::CMD_SPE: next_spoll = 1'b1;
          gmh_pkg::CMD_SPD: next_spoll = 1'b0;
          gmh_pkg::CMD_PPC, gmh_pkg::CMD_PPU: next_spoll = spoll;
          default: next_spoll = spoll;
        endcase
      end
    end else if (bus.ctl_dav && listen) begin
      next_rx_data = bus.ctl_dio;
      next_rx_valid = 1'b1;
    end
    // never drives while attention is up
    if (talk && !bus.atn && !bus.ifc && !dav) begin
      if (spoll) begin
        if (!sb_sent) begin
          next_dio = 8'h00;
          next_dio[gmh_pkg::SB_RQS_BIT] = srq_pend;
          next_dio[gmh_pkg::SB_REASON_W-1:0] = i_reason;
          next_dav = 1'b1;
          next_sb_sent = 1'b1;
          next_srq_pend = srq_pend & i_need_service;
        end
      end else if (i_tx_valid && tx_ready) begin
        next_dio = i_tx_data;
        next_dav = 1'b1;
      end
    end
    if (i_local_req && !lockout) begin
      next_remote = 1'b0;
    end
    if (!bus.ren) begin
      next_remote = 1'b0;
      next_lockout = 1'b0;
    end
    if (!i_need_service) begin
      next_srq_pend = 1'b0;
    end
    // a new request wins over a clear
    if (i_need_service && !need_q) begin
      next_srq_pend = 1'b1;
    end
    next_tx_ready = next_talk && !next_spoll && !bus.atn && !next_dav;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      listen <= 1'b0;
      talk <= 1'b0;
      spoll <= 1'b0;
      sb_sent <= 1'b0;
      remote <= 1'b0;
      lockout <= 1'b0;
      srq_pend <= 1'b0;
      need_q <= 1'b0;
      dio <= 8'h00;
      dav <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      trig <= 1'b0;
      clr <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      listen <= next_listen;
      talk <= next_talk;
      spoll <= next_spoll;
      sb_sent <= next_sb_sent;
      remote <= next_remote;
      lockout <= next_lockout;
      srq_pend <= next_srq_pend;
      need_q <= i_need_service;
      dio <= next_dio;
      dav <= next_dav;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      trig <= next_trig;
      clr <= next_clr;
      tx_ready <= next_tx_ready;
    end
  end

  assign bus.dev_dio = dio;
  assign bus.dev_dav = dav;
  assign bus.srq = srq_pend;
  assign o_tx_ready = tx_ready;
  assign o_rx_data = rx_data;
  assign o_rx_valid = rx_valid;
  assign o_trigger = trig;
  assign o_clear = clr;
  assign o_remote = remote;
  assign o_lockout = lockout;

endmodule

//--- hw/gmh_controller.sv
// controller end: sequences bus messages for each operation requested while active, or for an abort
//
// What this block and the instrument end do together
// - address talker and listeners before data
// - addressed devices start trigger function together
// - assert REN before sending trigger
// - clear sent addressed or universal, command mode
// - only system controller sets remote via REN
// - REN then listen address puts device remote
// - local message returns listeners to panel
// - lockout blocks front panel local key
// - REN false ends lockout, all local
// - SRQ held until cause gone, polled or not
// - polled device returns eight-bit status byte
// - poll: command mode, enable, then talk address
// - SRQ released after poll if cause gone
// - poll ends with serial poll disable
// - no parallel poll answer, configuration ignored
// - pass control: talk address then take control
// - abort with interface clear regains control
`timescale 1ns/1ps
module gmh_controller #(
  parameter logic [4:0] CTL_ADDR = 5'h15,
  parameter int IFC_CYCLES = gmh_pkg::IFC_CYCLES,
  parameter int POLL_WAIT = gmh_pkg::POLL_WAIT_CYCLES
) (
  input wire logic i_clk, // system clock
  input wire logic i_reset_n, // async reset, active low
  gmh_bus_if.ctl bus, // bus to devices
  input wire logic [3:0] i_op, // operation code
  input wire logic [4:0] i_addr, // target bus address
  input wire logic [7:0] i_data, // data byte for send
  input wire logic i_op_valid, // operation offered
  output logic o_op_ready, // idle, operation may be taken
  output logic [7:0] o_rx_data, // byte from a device
  output logic o_rx_valid, // byte pulse
  output logic o_poll_timeout, // poll got no answer, pulse
  output logic o_active, // this end is active controller
  output logic o_srq // service request seen
);

  typedef enum logic [3:0] {
    CS_IDLE = 4'b0001,
    CS_IFC = 4'b0010,
    CS_SEND = 4'b0100,
    CS_WAIT = 4'b1000
  } gmh_cstate_e;

  localparam int CNT_W = 16;
  localparam int SEQ_N = gmh_pkg::SEQ_DEPTH;

  gmh_cstate_e state, next_state;
  logic [1:0] seq_kind [SEQ_N];
  logic [7:0] seq_byte [SEQ_N];
  logic [1:0] next_seq_kind [SEQ_N];
  logic [7:0] next_seq_byte [SEQ_N];
  logic [2:0] seq_len, next_seq_len, idx, next_idx;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic atn, ren, ifc, dav, active, ready, rx_valid, tmo, srq;
  logic next_atn, next_ren, next_ifc, next_dav, next_active, next_rx_valid, next_tmo;
  logic [7:0] dio, next_dio, rx_data, next_rx_data;
  logic pass_pending, next_pass_pending;
  logic next_ready;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_seq_kind = seq_kind;
    next_seq_byte = seq_byte;
    next_seq_len = seq_len;
    next_idx = idx;
    next_cnt = cnt;
    next_atn = atn;
    next_ren = ren;
    next_ifc = ifc;
    next_dav = 1'b0;
    next_dio = dio;
    next_active = active;
    next_pass_pending = pass_pending;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    next_tmo = 1'b0;
    if (bus.dev_dav) begin
      next_rx_data = bus.dev_dio;
      next_rx_valid = 1'b1;
    end
    case (state)
      CS_IDLE: begin
        if (i_op_valid && (active || i_op == gmh_pkg::OP_ABORT)) begin
          next_idx = 3'h0;
          next_seq_len = 3'h0;
          next_state = CS_SEND;
          for (int k = 0; k < SEQ_N; k++) begin
            next_seq_kind[k] = gmh_pkg::STEP_CMD;
            next_seq_byte[k] = gmh_pkg::CMD_UNL;
          end
          case (i_op)
            gmh_pkg::OP_SEND_DATA: begin
              next_seq_byte[0] = gmh_pkg::CMD_UNL;
              next_seq_byte[1] = gmh_pkg::addr_byte(gmh_pkg::TALK_BASE, CTL_ADDR);
              next_seq_byte[2] = gmh_pkg::addr_byte(gmh_pkg::LISTEN_BASE, i_addr);
              next_seq_kind[3] = gmh_pkg::STEP_DATA;
              next_seq_byte[3] = i_data;
              next_seq_len = 3'h4;
            end
            gmh_pkg::OP_TRIGGER: begin
              next_ren = 1'b1;
              next_seq_byte[0] = gmh_pkg::addr_byte(gmh_pkg::LISTEN_BASE, i_addr);
              next_seq_byte[1] = gmh_pkg::CMD_GET;
              next_seq_len = 3'h2;
            end
            gmh_pkg::OP_CLR_ADDR: begin
              next_seq_byte[0] = gmh_pkg::addr_byte(gmh_pkg::LISTEN_BASE, i_addr);
              next_seq_byte[1] = gmh_pkg::CMD_SDC;
              next_seq_len = 3'h2;
            end
            gmh_pkg::OP_CLR_ALL: begin
              next_seq_byte[0] = gmh_pkg::CMD_DCL;
              next_seq_len = 3'h1;
            end
            gmh_pkg::OP_REMOTE: begin
              next_ren = 1'b1;
              next_seq_byte[0] = gmh_pkg::addr_byte(gmh_pkg::LISTEN_BASE, i_addr);
              next_seq_len = 3'h1;
            end
            gmh_pkg::OP_LOCAL: begin
              next_seq_byte[0] = gmh_pkg::addr_byte(gmh_pkg::LISTEN_BASE, i_addr);
              next_seq_byte[1] = gmh_pkg::CMD_GTL;
              next_seq_len = 3'h2;
            end
            gmh_pkg::OP_LOCKOUT: begin
              next_seq_byte[0] = gmh_pkg::CMD_LLO;
              next_seq_len = 3'h1;
            end
            gmh_pkg::OP_REN_OFF: begin
              // dropping ren returns all to local
              next_ren = 1'b0;
              next_state = CS_IDLE;
            end
            gmh_pkg::OP_SPOLL: begin
              next_seq_byte[0] = gmh_pkg::CMD_SPE;
              next_seq_byte[1] = gmh_pkg::addr_byte(gmh_pkg::TALK_BASE, i_addr);
              next_seq_kind[2] = gmh_pkg::STEP_WAIT;
              next_seq_byte[3] = gmh_pkg::CMD_SPD;
              next_seq_len = 3'h4;
            end
            gmh_pkg::OP_PASS: begin
              next_seq_byte[0] = gmh_pkg::addr_byte(gmh_pkg::TALK_BASE, i_addr);
              next_seq_byte[1] = gmh_pkg::CMD_TCT;
              next_seq_len = 3'h2;
              next_pass_pending = 1'b1;
            end
            gmh_pkg::OP_ABORT: begin
              next_ifc = 1'b1;
              next_active = 1'b1;
              next_cnt = CNT_W'(IFC_CYCLES - 1);
              next_state = CS_IFC;
            end
            default: next_state = CS_IDLE;
          endcase
        end
      end
      CS_IFC: begin
        if (cnt == '0) begin
          next_ifc = 1'b0;
          next_state = CS_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      CS_SEND: begin
        if (idx == seq_len) begin
          next_atn = 1'b0;
          if (pass_pending) begin
            next_active = 1'b0;
            next_pass_pending = 1'b0;
          end
          next_state = CS_IDLE;
        end else if (seq_kind[idx[1:0]] == gmh_pkg::STEP_WAIT) begin
          next_atn = 1'b0;
          next_cnt = CNT_W'(POLL_WAIT - 1);
          next_idx = idx + 3'h1;
          next_state = CS_WAIT;
        end else begin
          next_atn = (seq_kind[idx[1:0]] == gmh_pkg::STEP_CMD);
          next_dio = seq_byte[idx[1:0]];
          next_dav = 1'b1;
          next_idx = idx + 3'h1;
        end
      end
      CS_WAIT: begin
        if (bus.dev_dav) begin
          next_state = CS_SEND;
        end else if (cnt == '0) begin
          next_tmo = 1'b1;
          next_state = CS_SEND;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = CS_IDLE;
    endcase
    // one operation per idle visit
    next_ready = (next_state == CS_IDLE) && !(state == CS_IDLE && i_op_valid);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= CS_IDLE;
      for (int k = 0; k < SEQ_N; k++) begin
        seq_kind[k] <= gmh_pkg::STEP_CMD;
        seq_byte[k] <= 8'h00;
      end
      seq_len <= 3'h0;
      idx <= 3'h0;
      cnt <= '0;
      atn <= 1'b0;
      ren <= 1'b0;
      ifc <= 1'b0;
      dav <= 1'b0;
      dio <= 8'h00;
      active <= 1'b1;
      pass_pending <= 1'b0;
      ready <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      tmo <= 1'b0;
      srq <= 1'b0;
    end else begin
      state <= next_state;
      seq_kind <= next_seq_kind;
      seq_byte <= next_seq_byte;
      seq_len <= next_seq_len;
      idx <= next_idx;
      cnt <= next_cnt;
      atn <= next_atn;
      ren <= next_ren;
      ifc <= next_ifc;
      dav <= next_dav;
      dio <= next_dio;
      active <= next_active;
      pass_pending <= next_pass_pending;
      ready <= next_ready;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      tmo <= next_tmo;
      srq <= bus.srq;
    end
  end

  assign bus.atn = atn;
  assign bus.ren = ren;
  assign bus.ifc = ifc;
  assign bus.ctl_dio = dio;
  assign bus.ctl_dav = dav;
  assign o_op_ready = ready;
  assign o_rx_data = rx_data;
  assign o_rx_valid = rx_valid;
  assign o_poll_timeout = tmo;
  assign o_active = active;
  assign o_srq = srq;

endmodule

//--- sim/gmh_bus_sva.sv
// concurrent checks on the bus between controller and instrument ends
`timescale 1ns/1ps
module gmh_bus_sva #(
  parameter int IFC_CYCLES = gmh_pkg::IFC_CYCLES
) (
  input wire logic i_clk, // system clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic atn, // command mode
  input wire logic ren, // remote enable
  input wire logic ifc, // interface clear
  input wire logic [7:0] ctl_dio, // controller byte
  input wire logic ctl_dav, // controller byte valid
  input wire logic [7:0] dev_dio, // device byte
  input wire logic dev_dav, // device byte valid
  input wire logic srq // service request
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic cmd, lsn, tlk, lsn_ok, next_lsn_ok, poll, next_poll;
  int ifc_cnt, next_ifc_cnt;
  assign cmd = ctl_dav && atn;
  assign lsn = cmd && (ctl_dio & gmh_pkg::GROUP_MASK) == gmh_pkg::LISTEN_BASE
    && ctl_dio != gmh_pkg::CMD_UNL;
  assign tlk = cmd && (ctl_dio & gmh_pkg::GROUP_MASK) == gmh_pkg::TALK_BASE
    && ctl_dio != gmh_pkg::CMD_UNT;
  always_comb begin
    next_lsn_ok = lsn_ok;
    if (lsn) next_lsn_ok = 1'b1;
    if (cmd && ctl_dio == gmh_pkg::CMD_UNL) next_lsn_ok = 1'b0;
    next_poll = poll;
    if (cmd && ctl_dio == gmh_pkg::CMD_SPE) next_poll = 1'b1;
    if ((cmd && ctl_dio == gmh_pkg::CMD_SPD) || ifc) next_poll = 1'b0;
    next_ifc_cnt = ifc ? ifc_cnt + 1 : 0;
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lsn_ok <= 1'b0;
      poll <= 1'b0;
      ifc_cnt <= 0;
    end else begin
      lsn_ok <= next_lsn_ok;
      poll <= next_poll;
      ifc_cnt <= next_ifc_cnt;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_cmd(logic [7:0] c);
    cmd && ctl_dio == c;
  endsequence
  sequence s_talk;
    tlk;
  endsequence
  a_data_after_addr: assert property (ctl_dav && !atn |-> lsn_ok)
    else $error("data byte without listener addressed");
  a_trigger_needs_ren: assert property (s_cmd(gmh_pkg::CMD_GET) |-> ren)
    else $error("trigger sent with remote enable low");
  // a data byte may carry any value, so only command-mode clears are judged
  a_clear_in_cmd: assert property (s_cmd(gmh_pkg::CMD_SDC) |-> lsn_ok)
    else $error("addressed clear sent with no listener addressed");
  a_local_after_lsn: assert property (s_cmd(gmh_pkg::CMD_GTL) |-> $past(lsn))
    else $error("local message not preceded by listen address");
  a_status_byte_form: assert property (dev_dav && poll |->
    !dev_dio[7] && dev_dio[gmh_pkg::SB_RQS_BIT] == $past(srq))
    else $error("status byte request bit wrong");
  a_poll_enable_talk: assert property (s_cmd(gmh_pkg::CMD_SPE) |=> s_talk)
    else $error("poll enable not followed by talk address");
  a_poll_ends_spd: assert property (dev_dav && poll |->
    ##[1:40] s_cmd(gmh_pkg::CMD_SPD))
    else $error("serial poll not closed by disable");
  a_no_ppoll_answer: assert property (atn |-> !dev_dav)
    else $error("device drove a byte in command mode");
  a_pass_after_talk: assert property (s_cmd(gmh_pkg::CMD_TCT) |-> $past(tlk))
    else $error("take control without talk address");
  a_ifc_length: assert property ($fell(ifc) |-> ifc_cnt == IFC_CYCLES)
    else $error("interface clear length wrong");
endmodule

//--- sim/test_gmh_device_message_handler.sv
// self-checking bench joining controller end and instrument end
`timescale 1ns/1ps
module test_gmh_device_message_handler;
  localparam logic [4:0] MY = 5'h0b;
  localparam logic [4:0] OT = 5'h03;
  localparam int IFC_N = 4;
  typedef struct {logic [3:0] op; logic [4:0] a; logic [7:0] d;
    logic [1:0] trig, clr, rem, rx;} gmh_row_s;
  logic i_clk = 1'b0, i_reset_n = 1'b0;
  logic d_local, d_need, d_txv, d_txr, d_rxv, d_trig, d_clr, d_rem, d_lk;
  logic [5:0] d_reason;
  logic [7:0] d_txd, d_rxd, c_data, c_rxd, drx, crx;
  logic [3:0] c_op;
  logic [4:0] c_addr;
  logic c_valid, c_ready, c_rxv, c_to, c_act, c_srq;
  int errors = 0, n_compared = 0, n_trig, n_clr, n_drx, n_crx, n_to;
  gmh_row_s rows[11] = '{
    '{gmh_pkg::OP_REMOTE, MY, 8'h00, 0, 0, 1, 0},
    '{gmh_pkg::OP_SEND_DATA, MY, 8'ha5, 0, 0, 1, 1},
    '{gmh_pkg::OP_TRIGGER, MY, 8'h00, 1, 0, 1, 0},
    '{gmh_pkg::OP_CLR_ADDR, MY, 8'h00, 0, 1, 1, 0},
    '{gmh_pkg::OP_SEND_DATA, OT, 8'h5a, 0, 0, 1, 0},
    '{gmh_pkg::OP_TRIGGER, OT, 8'h00, 0, 0, 1, 0},
    '{gmh_pkg::OP_CLR_ADDR, OT, 8'h00, 0, 0, 1, 0},
    '{gmh_pkg::OP_LOCAL, OT, 8'h00, 0, 0, 1, 0},
    '{gmh_pkg::OP_CLR_ALL, OT, 8'h00, 0, 1, 1, 0},
    '{gmh_pkg::OP_LOCAL, MY, 8'h00, 0, 0, 0, 0},
    '{gmh_pkg::OP_REMOTE, MY, 8'h00, 0, 0, 1, 0}};
  always #10 i_clk = ~i_clk;
  gmh_bus_if gmh_bus_if_i ();
  gmh_device #(.MY_ADDR(MY)) gmh_device_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .bus(gmh_bus_if_i.dev), .i_local_req(d_local), .i_need_service(d_need),
    .i_reason(d_reason), .i_tx_data(d_txd), .i_tx_valid(d_txv), .o_tx_ready(d_txr),
    .o_rx_data(d_rxd), .o_rx_valid(d_rxv), .o_trigger(d_trig), .o_clear(d_clr),
    .o_remote(d_rem), .o_lockout(d_lk));
  gmh_controller #(.IFC_CYCLES(IFC_N)) gmh_controller_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .bus(gmh_bus_if_i.ctl), .i_op(c_op), .i_addr(c_addr),
    .i_data(c_data), .i_op_valid(c_valid), .o_op_ready(c_ready), .o_rx_data(c_rxd),
    .o_rx_valid(c_rxv), .o_poll_timeout(c_to), .o_active(c_act), .o_srq(c_srq));
  gmh_bus_sva #(.IFC_CYCLES(IFC_N)) gmh_bus_sva_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .atn(gmh_bus_if_i.atn), .ren(gmh_bus_if_i.ren),
    .ifc(gmh_bus_if_i.ifc), .ctl_dio(gmh_bus_if_i.ctl_dio),
    .ctl_dav(gmh_bus_if_i.ctl_dav), .dev_dio(gmh_bus_if_i.dev_dio),
    .dev_dav(gmh_bus_if_i.dev_dav), .srq(gmh_bus_if_i.srq));
  // single-cycle pulses are counted on the edge that samples them
  always @(posedge i_clk) begin
    if (d_trig === 1'b1) n_trig++;
    if (d_clr === 1'b1) n_clr++;
    if (d_rxv === 1'b1) begin n_drx++; drx = d_rxd; end
    if (c_rxv === 1'b1) begin n_crx++; crx = c_rxd; end
    if (c_to === 1'b1) n_to++;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run_op(input logic [3:0] op, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    c_op <= op; c_addr <= a; c_data <= d; c_valid <= 1'b1;
    do begin @(posedge i_clk); n++; end while (c_ready !== 1'b1 && n < 50);
    c_valid <= 1'b0;
    do begin @(posedge i_clk); n++; end while (c_ready !== 1'b1 && n < 200);
    if (n >= 200) chk(8'h01, 8'h00);
    repeat (2) @(posedge i_clk);
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  initial begin
    wait_n(20000);
    errors++;
    summarize();
  end
  initial begin
    int n;
    d_local = 0; d_need = 0; d_reason = 6'h2a; d_txd = 8'h00; d_txv = 0;
    c_op = 4'h0; c_addr = 5'h00; c_data = 8'h00; c_valid = 0;
    wait_n(10);
    i_reset_n <= 1'b1;
    wait_n(2);
    chk({c_act, c_ready, d_rem, d_lk, c_srq}, 8'h18);
    $display("reset test done");
    foreach (rows[i]) begin
      n_trig = 0; n_clr = 0; n_drx = 0;
      run_op(rows[i].op, rows[i].a, rows[i].d);
      chk(n_trig, rows[i].trig);
      chk(n_clr, rows[i].clr);
      chk(d_rem, rows[i].rem);
      chk(n_drx, rows[i].rx);
      if (rows[i].rx) chk(drx, rows[i].d);
    end
    $display("table test done");
    run_op(gmh_pkg::OP_LOCKOUT, MY, 8'h00);
    @(posedge i_clk) d_local <= 1'b1;
    wait_n(3);
    chk({d_rem, d_lk}, 8'h03);
    @(posedge i_clk) d_local <= 1'b0;
    run_op(gmh_pkg::OP_REN_OFF, MY, 8'h00);
    chk({d_rem, d_lk}, 8'h00);
    run_op(gmh_pkg::OP_REMOTE, MY, 8'h00);
    @(posedge i_clk) d_local <= 1'b1;
    wait_n(3);
    chk(d_rem, 8'h00);
    @(posedge i_clk) d_local <= 1'b0;
    $display("lockout test done");
    @(posedge i_clk) d_need <= 1'b1;
    wait_n(3);
    chk(c_srq, 8'h01);
    n_crx = 0; n_to = 0;
    run_op(gmh_pkg::OP_SPOLL, MY, 8'h00);
    chk(crx, (8'h01 << gmh_pkg::SB_RQS_BIT) | 8'h2a);
    chk({n_crx[3:0], n_to[3:0]}, 8'h10);
    chk(c_srq, 8'h01);
    @(posedge i_clk) d_need <= 1'b0;
    wait_n(3);
    chk(c_srq, 8'h00);
    run_op(gmh_pkg::OP_SPOLL, MY, 8'h00);
    chk(crx, 8'h2a);
    n_crx = 0; n = 0;
    @(posedge i_clk) begin d_txd <= 8'hc3; d_txv <= 1'b1; end
    do begin @(posedge i_clk); n++; end while (d_txr !== 1'b1 && n < 50);
    d_txv <= 1'b0;
    wait_n(3);
    chk(crx, 8'hc3);
    chk(n_crx, 8'h01);
    run_op(gmh_pkg::OP_SPOLL, OT, 8'h00);
    chk(n_to, 8'h01);
    $display("poll test done");
    run_op(gmh_pkg::OP_PASS, OT, 8'h00);
    chk(c_act, 8'h00);
    n_trig = 0;
    run_op(gmh_pkg::OP_TRIGGER, MY, 8'h00);
    chk(n_trig, 8'h00);
    run_op(gmh_pkg::OP_ABORT, OT, 8'h00);
    chk(c_act, 8'h01);
    run_op(gmh_pkg::OP_PASS, OT, 8'h00);
    @(posedge i_clk) i_reset_n <= 1'b0;
    wait_n(2);
    i_reset_n <= 1'b1;
    wait_n(2);
    chk({c_act, c_ready, d_rem}, 8'h06);
    $display("control test done");
    summarize();
  end
endmodule
